// ==== verilog/fec_ctrl_pkg.sv ====
`default_nettype none
package fec_ctrl_pkg;
    // Wishbone word offsets (byte address = index * 4)
    localparam logic [7:0] LANE0_CTRL_IDX = 8'hb2;
    localparam logic [7:0] LANE1_CTRL_IDX = 8'hb5;
    localparam logic [7:0] LANE3_CTRL_IDX = 8'hbb;
    localparam logic [7:0] LOCK_STATUS_IDX = 8'hb0;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'hf0;
    localparam logic [7:0] IRQ_MASK_IDX = 8'hf1;
    localparam logic [7:0] COUNTER_IDX = 8'hf2;
    // Per-lane count window base: corrected then uncorrected bytes
    localparam logic [11:0] XCVR_CORR_BASE = 12'h0dc;
    localparam logic [11:0] XCVR_UNCORR_BASE = 12'h0e0;
    localparam logic [11:0] XCVR_LANE1_OFFSET = 12'h400;
    localparam logic [11:0] XCVR_LANE3_OFFSET = 12'hc00;
    // Control bit fields
    localparam int INSERT_BIT = 11;
    localparam int CLEAR_BIT = 12;
    localparam int LOCK_LSB = 20;
    localparam int LANES = 4;
    localparam logic [3:0] LOCK_RESET = 4'h0;
    // Interrupt status bits
    localparam int IRQ_LOCK_CHANGE = 0;
    localparam int IRQ_INSERT_DONE = 1;
    localparam int IRQ_WIDTH = 2;
endpackage
`default_nettype wire

// ==== verilog/kr4_fec_error_control.sv ====
// Summary of operation
// - Read-only four-bit lock field, bit 20 lane 0 to bit 23 lane 3, reset zero.
// - Writing one to lane insert bit gives one error pulse; bit self-clears.
// - Clear bit held one holds lane counters reset; zero resumes counting.
// - Each lane keeps 32-bit corrected and 32-bit uncorrected block counters.
// - Lane 0 corrected count read as four bytes, LSB at 0xdc.
// - Lane 0 uncorrected count read as four bytes, LSB at 0xe0.
// - Lane 1 control copy; its transceiver range is displaced by 0x400.
// - Lane 3 control copy; its transceiver range is displaced by 0xc00.
//
// Chosen here: the Wishbone interface to the registers.
`default_nettype none
module kr4_fec_error_control #(
    parameter int CNT_WIDTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Lane status and FEC events
    input wire logic [3:0] blockLock,
    input wire logic [3:0] blockCorrected,
    input wire logic [3:0] blockUncorrected,
    // Transceiver count read port (byte wide)
    input wire logic [11:0] xcvrAddr,
    input wire logic xcvrRead,
    output logic [7:0] xcvrData,
    // Error injection pulses, type preset in transceiver
    output logic [3:0] errInject,
    output logic [3:0] clearBlockTallies,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    localparam int IRQ_W = fec_ctrl_pkg::IRQ_WIDTH;
    logic [3:0] lock_q, lock_d;
    logic [3:0] clr_q, clr_d;
    logic [3:0] inj_q, inj_d;
    logic [IRQ_W-1:0] sts_q, sts_d;
    logic [IRQ_W-1:0] msk_q, msk_d;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d;
    logic irq_q, irq_d;
    logic [7:0] xd_q, xd_d;
    logic [CNT_WIDTH-1:0] corr_q [4];
    logic [CNT_WIDTH-1:0] corr_d [4];
    logic [CNT_WIDTH-1:0] unc_q [4];
    logic [CNT_WIDTH-1:0] unc_d [4];

    logic busReq;
    logic wrReq;
    logic irqWr;
    logic rdReq;
    logic insertEvent;
    logic lockEvent;
    logic [7:0] idx;
    logic hit;
    logic [1:0] hitLane;

    assign idx = adr_i[9:2];
    assign busReq = cyc_i && stb_i && !ack_q;
    assign wrReq = busReq && we_i && sel_i[1];
    assign irqWr = busReq && we_i && sel_i[0];
    assign rdReq = busReq && !we_i;

    ////////////////////////////////////////////////////////////////////////
    // Decode control register index to lane (no lane 2 copy)
    always_comb begin
        hit = 1'b0;
        hitLane = 2'd0;
        case (idx)
            fec_ctrl_pkg::LANE0_CTRL_IDX: begin
                hit = 1'b1;
                hitLane = 2'd0;
            end
            fec_ctrl_pkg::LANE1_CTRL_IDX: begin
                hit = 1'b1;
                hitLane = 2'd1;
            end
            fec_ctrl_pkg::LANE3_CTRL_IDX: begin
                hit = 1'b1;
                hitLane = 2'd3;
            end
            default: hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock sampling and change detect
    always_comb begin
        lock_d = blockLock;
        lockEvent = lock_q != blockLock;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= fec_ctrl_pkg::LOCK_RESET;
        end else begin
            lock_q <= lock_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-lane insert pulse and counter clear level
    always_comb begin
        clr_d = clr_q;
        inj_d = 4'h0;
        insertEvent = 1'b0;
        // One pulse per taken write; ack_q gate stops repeats
        if (wrReq && hit) begin
            inj_d[hitLane] = dat_i[fec_ctrl_pkg::INSERT_BIT];
            clr_d[hitLane] = dat_i[fec_ctrl_pkg::CLEAR_BIT];
            insertEvent = dat_i[fec_ctrl_pkg::INSERT_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_q <= 4'h0;
            inj_q <= 4'h0;
        end else begin
            clr_q <= clr_d;
            inj_q <= inj_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt mask
    always_comb begin
        msk_d = msk_q;
        if (irqWr && idx == fec_ctrl_pkg::IRQ_MASK_IDX) begin
            msk_d = dat_i[IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            msk_q <= '0;
        end else begin
            msk_q <= msk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status and level interrupt
    always_comb begin
        logic [IRQ_W-1:0] ev;
        ev = '0;
        ev[fec_ctrl_pkg::IRQ_LOCK_CHANGE] = lockEvent;
        ev[fec_ctrl_pkg::IRQ_INSERT_DONE] = insertEvent;
        sts_d = sts_q;
        if (irqWr && idx == fec_ctrl_pkg::IRQ_STATUS_IDX) begin
            sts_d = sts_q & ~dat_i[IRQ_W-1:0];
        end
        // Set wins over a same-cycle clear
        sts_d = sts_d | ev;
        irq_d = |(sts_d & msk_d);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sts_q <= '0;
            irq_q <= 1'b0;
        end else begin
            sts_q <= sts_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One-cycle acknowledge, never two in a row
    always_comb begin
        ack_d = busReq;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, held until the next read
    always_comb begin
        dat_d = dat_q;
        if (rdReq) begin
            dat_d = 32'h0000_0000;
            if (hit) begin
                // Insert bit self-clears: always reads zero
                dat_d[fec_ctrl_pkg::CLEAR_BIT] = clr_q[hitLane];
            end
            case (idx)
                fec_ctrl_pkg::LANE0_CTRL_IDX:
                    dat_d[fec_ctrl_pkg::LOCK_LSB +: 4] = lock_q;
                fec_ctrl_pkg::LOCK_STATUS_IDX:
                    dat_d[3:0] = lock_q;
                fec_ctrl_pkg::IRQ_STATUS_IDX:
                    dat_d[IRQ_W-1:0] = sts_q;
                fec_ctrl_pkg::IRQ_MASK_IDX:
                    dat_d[IRQ_W-1:0] = msk_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dat_q <= 32'h0000_0000;
        end else begin
            dat_q <= dat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-lane block counters
    generate
        for (genvar g = 0; g < fec_ctrl_pkg::LANES; g++) begin : gLane
            always_comb begin
                corr_d[g] = corr_q[g];
                unc_d[g] = unc_q[g];
                if (clr_q[g]) begin
                    corr_d[g] = '0;
                    unc_d[g] = '0;
                end else begin
                    if (blockCorrected[g]) begin
                        corr_d[g] = corr_q[g] + 1'b1;
                    end
                    if (blockUncorrected[g]) begin
                        unc_d[g] = unc_q[g] + 1'b1;
                    end
                end
            end
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    corr_q[g] <= '0;
                    unc_q[g] <= '0;
                end else begin
                    corr_q[g] <= corr_d[g];
                    unc_q[g] <= unc_d[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Transceiver byte window: lane n at base + n*0x400
    logic [1:0] xLane;
    logic [11:0] xOff;
    logic inCorr;
    logic inUnc;

    always_comb begin
        xLane = xcvrAddr[11:10];
        xOff = {2'b00, xcvrAddr[9:0]};
        inCorr = xOff >= fec_ctrl_pkg::XCVR_CORR_BASE
            && xOff < fec_ctrl_pkg::XCVR_UNCORR_BASE;
        inUnc = xOff >= fec_ctrl_pkg::XCVR_UNCORR_BASE
            && xOff < fec_ctrl_pkg::XCVR_UNCORR_BASE + 12'h004;
    end

    always_comb begin
        logic [31:0] word;
        word = 32'h0000_0000;
        xd_d = xd_q;
        if (xcvrRead) begin
            xd_d = 8'h00;
            if (inCorr) begin
                word = 32'(corr_q[xLane]);
                xd_d = word[8*xOff[1:0] +: 8];
            end else if (inUnc) begin
                word = 32'(unc_q[xLane]);
                xd_d = word[8*xOff[1:0] +: 8];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xd_q <= 8'h00;
        end else begin
            xd_q <= xd_d;
        end
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign irq = irq_q;
    assign xcvrData = xd_q;
    assign errInject = inj_q;
    assign clearBlockTallies = clr_q;

endmodule
`default_nettype wire

// ==== testbench/kr4_fec_error_control_asserts.sv ====
`default_nettype none
module kr4_fec_error_control_asserts (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic [11:0] xcvrAddr,
    input wire logic xcvrRead,
    input wire logic [7:0] xcvrData,
    input wire logic [3:0] errInject,
    input wire logic [3:0] clearBlockTallies
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic tk = cyc_i && stb_i && !ack_o && we_i && sel_i[1];
    wire logic [7:0] ix = adr_i[9:2];
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    a_insert_lane0: assert property (tk && ix == 8'hb2 && dat_i[11]
        |=> errInject[0]) else $error("lane 0 pulse missing");
    a_insert_cause: assert property (errInject[0]
        |-> $past(tk && ix == 8'hb2 && dat_i[11])) else $error("stray pulse");
    a_insert_lane1: assert property (tk && ix == 8'hb5 && dat_i[11]
        |=> errInject[1]) else $error("lane 1 pulse missing");
    a_insert_lane3: assert property (tk && ix == 8'hbb && dat_i[11]
        |=> errInject[3]) else $error("lane 3 pulse missing");
    a_clear_level: assert property (tk && ix == 8'hb2
        |=> clearBlockTallies[0] == $past(dat_i[12])) else $error("clear bad");
    a_cleared_zero: assert property (clearBlockTallies[0]
        && $past(clearBlockTallies[0]) && xcvrRead && xcvrAddr[11:10] == 2'b00
        |=> xcvrData == 8'h00) else $error("count not held at zero");
endmodule
////////////////////////////////////////////////////////////////////////////
bind kr4_fec_error_control kr4_fec_error_control_asserts u_asserts (
    .ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .xcvrAddr(xcvrAddr), .xcvrRead(xcvrRead), .xcvrData(xcvrData),
    .errInject(errInject), .clearBlockTallies(clearBlockTallies));
`default_nettype wire

// ==== testbench/kr4_fec_error_control_tb.sv ====
`default_nettype none
module kr4_fec_error_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, cyc, stb, we, ack, xr, irq;
    logic [9:0] adr;
    logic [31:0] dat, rdo, rd, xv;
    logic [3:0] lock, bc, bu, inj, clr, seen;
    logic [11:0] xa;
    logic [7:0] xd, errSetting;
    int failures, compares, pulses;
    kr4_fec_error_control dut (.ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat),
        .dat_o(rdo), .ack_o(ack), .blockLock(lock), .blockCorrected(bc),
        .blockUncorrected(bu), .xcvrAddr(xa), .xcvrRead(xr), .xcvrData(xd),
        .errInject(inj), .clearBlockTallies(clr), .irq(irq));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (inj !== 4'h0) begin
        pulses += 1;
        seen = inj;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] ix, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we} <= {2'b11, w};
        adr <= {ix, 2'b00};
        dat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 9);
        if (n >= 9) begin
            failures++;
            $display("CHECK FAILED t=%0t no ack", $time);
            stop_test();
        end else begin
            rd = rdo;
            {cyc, stb} <= 2'b00;
            @(posedge ref_clk);
        end
    endtask
    // Read-modify-write of the lane's error type setting byte
    task automatic pick_err(input logic burst, input logic [3:0] len);
        logic [7:0] v;
        v = errSetting;
        v[0] = !burst;
        v[1] = burst;
        v[7:4] = burst ? len : 4'h0;
        errSetting = v;
    endtask
    task automatic xrd(input logic [11:0] a);
        for (int k = 0; k < 4; k++) begin
            xr <= 1'b1;
            xa <= a + 12'(k);
            @(posedge ref_clk);
            xr <= 1'b0;
            @(posedge ref_clk);
            xv[8*k +: 8] = xd;
        end
    endtask
    task automatic ev(input logic [3:0] c, input logic [3:0] u);
        bc <= c;
        bu <= u;
        @(posedge ref_clk);
        {bc, bu} <= 8'h00;
        @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_lock();
        wb(1'b0, 8'hb2, 32'h0);
        chk(32'(rd[23:20]), 32'h0);
        lock <= 4'h9;
        wb(1'b0, 8'hff, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'hb2, 32'h0);
        chk(32'(rd[23:20]), 32'h9);
        wb(1'b0, 8'hb0, 32'h0);
        chk(rd, 32'h9);
        chk(32'(irq), 32'h0);
        wb(1'b1, 8'hf1, 32'h1);
        @(posedge ref_clk);
        chk(32'(irq), 32'h1);
        wb(1'b1, 8'hf0, 32'h1);
        @(posedge ref_clk);
        chk(32'(irq), 32'h0);
        $display("lock and irq test done");
    endtask
    task automatic t_insert();
        logic [7:0] ixs[3] = '{8'hb2, 8'hb5, 8'hbb};
        logic [3:0] ln[3] = '{4'h1, 4'h2, 4'h8};
        for (int i = 0; i < 3; i++) begin
            pick_err(i[0], 4'h3);
            chk(32'(errSetting[1:0]), i[0] ? 32'h2 : 32'h1);
            pulses = 0;
            wb(1'b1, ixs[i], 32'h800);
            wb(1'b0, ixs[i], 32'h0);
            chk(32'(pulses), 32'h1);
            chk(32'(seen), 32'(ln[i]));
            chk(32'(rd[11]), 32'h0);
            wb(1'b0, 8'hf0, 32'h0);
            chk(32'(rd[1]), 32'h1);
            pulses = 0;
            wb(1'b1, ixs[i], 32'h0);
            wb(1'b0, ixs[i], 32'h0);
            chk(32'(pulses), 32'h0);
        end
        $display("insert test done");
    endtask
    task automatic t_count();
        ev(4'h3, 4'h1);
        for (int n = 0; n < 257; n++) ev(4'h1, 4'h0);
        xrd(12'h0dc);
        chk(xv, 32'h102);
        xrd(12'h0e0);
        chk(xv, 32'h1);
        xrd(12'h4dc);
        chk(xv, 32'h1);
        wb(1'b1, 8'hb2, 32'h1000);
        chk(32'(clr), 32'h1);
        ev(4'h1, 4'h1);
        xrd(12'h0dc);
        chk(xv, 32'h0);
        wb(1'b1, 8'hb2, 32'h0);
        ev(4'h1, 4'h0);
        xrd(12'h0dc);
        chk(xv, 32'h1);
        $display("counter test done");
    endtask
    initial begin
        {cyc, stb, we, xr, rst_n} = 5'h0;
        {adr, dat, lock, bc, bu, xa} = '0;
        {failures, compares, pulses} = '0;
        errSetting = 8'h00;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_lock();
        t_insert();
        t_count();
        stop_test();
    end
endmodule
`default_nettype wire
